/* File: logic/mtis_alu.sv */
// combinational byte operations: nibble swap, xor and nil tests
`timescale 1ns/1ns
module mtis_alu (
  input wire logic [7:0] i_mem,
  input wire logic [7:0] i_wreg,
  input wire logic [7:0] i_imm,
  input wire logic [2:0] i_bit_sel,
  input wire logic i_use_imm,
  output logic [7:0] o_swapped,
  output logic [7:0] o_xor,
  output logic o_xor_nil,
  output logic o_byte_nil,
  output logic o_bit_nil
);
  localparam int N = mtis_pkg::NIBBLE_W;
  // upper nibble to lower half, lower nibble to upper half
  assign o_swapped = {i_mem[N-1:0], i_mem[2*N-1:N]};
  assign o_xor = i_wreg ^ (i_use_imm ? i_imm : i_mem);
  assign o_xor_nil = (o_xor == 8'h00);
  assign o_byte_nil = (i_mem == 8'h00);
  assign o_bit_nil = ~i_mem[i_bit_sel];
endmodule

/* File: logic/mtis_exec.sv */
// execution unit for nibble exchange, skip, table fetch and xor
`timescale 1ns/1ns
module mtis_exec #(
  parameter int PC_W = mtis_pkg::PC_W_DEF,
  parameter int TP_W = mtis_pkg::TP_W_DEF
) (
  input wire logic i_mclk,
  input wire logic i_rst_b,
  input wire logic i_ce,
  input wire logic i_issue,
  input wire logic [3:0] i_op,
  input wire logic [2:0] i_bit_sel,
  input wire logic [7:0] i_imm,
  input wire logic [7:0] i_mem_rdata,
  input wire logic [TP_W-1:0] i_table_pointer,
  input wire logic [PC_W-1:0] i_pc,
  input wire logic [15:0] i_rom_data,
  output logic o_ready,
  output logic o_discard,
  output logic [7:0] o_working_register,
  output logic [7:0] o_table_high_latch,
  output logic o_zero_flag,
  output logic o_mem_we,
  output logic [7:0] o_mem_wdata,
  output logic o_rom_en,
  output logic [PC_W-1:0] o_rom_addr
);
  localparam int PG_W = PC_W - TP_W;

  // refused at elaboration: the page field needs at least one bit
  if (TP_W < 1 || PG_W < 1) begin : g_width_check
    $error("table pointer must be narrower than program counter");
  end

  mtis_pkg::mtis_state_e state;
  mtis_pkg::mtis_state_e next_state;
  logic [7:0] swapped;
  logic [7:0] xor_res;
  logic xor_nil;
  logic byte_nil;
  logic bit_nil;
  logic accept;
  logic skip_hit;
  logic is_table;
  logic [PG_W-1:0] page;

  mtis_alu u_alu (
    .i_mem(i_mem_rdata),
    .i_wreg(o_working_register),
    .i_imm(i_imm),
    .i_bit_sel(i_bit_sel),
    .i_use_imm(i_op == mtis_pkg::OP_XOR_IMM),
    .o_swapped(swapped),
    .o_xor(xor_res),
    .o_xor_nil(xor_nil),
    .o_byte_nil(byte_nil),
    .o_bit_nil(bit_nil)
  );

  assign o_ready = (state == mtis_pkg::ST_IDLE);
  assign accept = i_ce && i_issue && o_ready;
  // the fetch side drops its prefetched word while the dummy cycle runs
  assign o_discard = (state == mtis_pkg::ST_DUMMY);
  assign o_rom_en = (state == mtis_pkg::ST_TABLE);
  assign is_table = (i_op == mtis_pkg::OP_TBL_CUR) ||
                    (i_op == mtis_pkg::OP_TBL_LAST);
  // last page is the page field forced to all ones
  assign page = (i_op == mtis_pkg::OP_TBL_LAST) ? {PG_W{1'b1}} :
                i_pc[PC_W-1:TP_W];

  always_comb begin
    unique case (i_op)
      mtis_pkg::OP_SKIP_NIL: skip_hit = byte_nil;
      mtis_pkg::OP_LOAD_SKIP: skip_hit = byte_nil;
      mtis_pkg::OP_SKIP_BIT: skip_hit = bit_nil;
      default: skip_hit = 1'b0;
    endcase
  end

  always_comb begin
    next_state = state;
    unique case (state)
      mtis_pkg::ST_IDLE: begin
        if (accept && skip_hit) begin
          next_state = mtis_pkg::ST_DUMMY;
        end else if (accept && is_table) begin
          next_state = mtis_pkg::ST_TABLE;
        end
      end
      mtis_pkg::ST_DUMMY: next_state = mtis_pkg::ST_IDLE;
      mtis_pkg::ST_TABLE: next_state = mtis_pkg::ST_IDLE;
      default: next_state = mtis_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge i_mclk) begin
    if (!i_rst_b) begin
      state <= mtis_pkg::ST_IDLE;
    end else if (i_ce) begin
      state <= next_state;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (!i_rst_b) begin
      o_working_register <= mtis_pkg::WREG_RST;
    end else if (accept) begin
      unique case (i_op)
        mtis_pkg::OP_SWAP_W: o_working_register <= swapped;
        mtis_pkg::OP_LOAD_SKIP: o_working_register <= i_mem_rdata;
        mtis_pkg::OP_XOR_MEM: o_working_register <= xor_res;
        mtis_pkg::OP_XOR_IMM: o_working_register <= xor_res;
        default: o_working_register <= o_working_register;
      endcase
    end
  end

  // only the xor forms touch the zero flag; every other op leaves it
  always_ff @(posedge i_mclk) begin
    if (!i_rst_b) begin
      o_zero_flag <= mtis_pkg::ZERO_RST;
    end else if (accept && (i_op == mtis_pkg::OP_XOR_MEM ||
                            i_op == mtis_pkg::OP_XOR_TO_MEM ||
                            i_op == mtis_pkg::OP_XOR_IMM)) begin
      o_zero_flag <= xor_nil;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (!i_rst_b) begin
      o_mem_we <= 1'b0;
      o_mem_wdata <= 8'h00;
    end else if (i_ce) begin
      o_mem_we <= 1'b0;
      if (state == mtis_pkg::ST_TABLE) begin
        o_mem_we <= 1'b1;
        o_mem_wdata <= i_rom_data[7:0];
      end else if (accept && i_op == mtis_pkg::OP_SWAP) begin
        o_mem_we <= 1'b1;
        o_mem_wdata <= swapped;
      end else if (accept && i_op == mtis_pkg::OP_XOR_TO_MEM) begin
        o_mem_we <= 1'b1;
        o_mem_wdata <= xor_res;
      end
    end
  end

  always_ff @(posedge i_mclk) begin
    if (!i_rst_b) begin
      o_rom_addr <= '0;
    end else if (accept && is_table) begin
      o_rom_addr <= {page, i_table_pointer};
    end
  end

  always_ff @(posedge i_mclk) begin
    if (!i_rst_b) begin
      o_table_high_latch <= mtis_pkg::TABLE_HIGH_LATCH_RST;
    end else if (i_ce && state == mtis_pkg::ST_TABLE) begin
      o_table_high_latch <= i_rom_data[15:8];
    end
  end

  // assertions assume the clock enable stays high across a sequence
  sequence s_accept_op(logic [3:0] op);
    accept && i_op == op;
  endsequence

  sequence s_dummy_then_idle;
    o_discard && !o_ready ##1 o_ready && !o_discard;
  endsequence

  a_swap_write: assert property (
    @(posedge i_mclk) disable iff (!i_rst_b || !i_ce)
    s_accept_op(mtis_pkg::OP_SWAP) |=> o_mem_we &&
      o_mem_wdata == {$past(i_mem_rdata[3:0]), $past(i_mem_rdata[7:4])})
    else $error("in-place swap wrote wrong byte");

  a_swap_working: assert property (
    @(posedge i_mclk) disable iff (!i_rst_b || !i_ce)
    s_accept_op(mtis_pkg::OP_SWAP_W) |=> !o_mem_we &&
      o_working_register ==
        {$past(i_mem_rdata[3:0]), $past(i_mem_rdata[7:4])})
    else $error("swap to working register wrong");

  a_skip_two_cycles: assert property (
    @(posedge i_mclk) disable iff (!i_rst_b || !i_ce)
    accept && skip_hit |=> s_dummy_then_idle)
    else $error("met skip did not take two cycles");

  a_noskip_one_cycle: assert property (
    @(posedge i_mclk) disable iff (!i_rst_b || !i_ce)
    accept && !skip_hit && !is_table |=> o_ready && !o_discard)
    else $error("unmet skip was not one cycle");

  a_skip_byte_nil: assert property (
    @(posedge i_mclk) disable iff (!i_rst_b || !i_ce)
    s_accept_op(mtis_pkg::OP_SKIP_NIL) |=>
      o_discard == ($past(i_mem_rdata) == 8'h00) && !o_mem_we)
    else $error("byte skip decision wrong");

  a_load_skip: assert property (
    @(posedge i_mclk) disable iff (!i_rst_b || !i_ce)
    s_accept_op(mtis_pkg::OP_LOAD_SKIP) |=>
      o_working_register == $past(i_mem_rdata) &&
      o_discard == (o_working_register == 8'h00))
    else $error("load and skip wrong");

  a_skip_bit_nil: assert property (
    @(posedge i_mclk) disable iff (!i_rst_b || !i_ce)
    s_accept_op(mtis_pkg::OP_SKIP_BIT) |=>
      o_discard == !$past(i_mem_rdata[i_bit_sel]) && !o_mem_we)
    else $error("bit skip decision wrong");

  a_table_fetch: assert property (
    @(posedge i_mclk) disable iff (!i_rst_b || !i_ce)
    accept && is_table |=> o_rom_en && !o_ready &&
      o_rom_addr[TP_W-1:0] == $past(i_table_pointer) ##1
      o_mem_we && o_ready && o_mem_wdata == $past(i_rom_data[7:0]) &&
      o_table_high_latch == $past(i_rom_data[15:8]))
    else $error("table fetch wrong");

  a_last_page: assert property (
    @(posedge i_mclk) disable iff (!i_rst_b || !i_ce)
    s_accept_op(mtis_pkg::OP_TBL_LAST) |=> &o_rom_addr[PC_W-1:TP_W])
    else $error("last page not all ones");

  a_xor_working: assert property (
    @(posedge i_mclk) disable iff (!i_rst_b || !i_ce)
    s_accept_op(mtis_pkg::OP_XOR_MEM) or
      s_accept_op(mtis_pkg::OP_XOR_IMM) |=>
      o_working_register == $past(o_working_register ^
        (i_op == mtis_pkg::OP_XOR_IMM ? i_imm : i_mem_rdata)) &&
      !o_mem_we)
    else $error("xor to working register wrong");

  a_xor_memory: assert property (
    @(posedge i_mclk) disable iff (!i_rst_b || !i_ce)
    s_accept_op(mtis_pkg::OP_XOR_TO_MEM) |=> o_mem_we &&
      o_mem_wdata == ($past(o_working_register) ^ $past(i_mem_rdata)) &&
      $stable(o_working_register))
    else $error("xor to memory wrong");

  a_xor_zero_flag: assert property (
    @(posedge i_mclk) disable iff (!i_rst_b || !i_ce)
    accept && (i_op == mtis_pkg::OP_XOR_MEM ||
      i_op == mtis_pkg::OP_XOR_TO_MEM ||
      i_op == mtis_pkg::OP_XOR_IMM) |=>
      o_zero_flag == ($past(o_working_register ^
        (i_op == mtis_pkg::OP_XOR_IMM ? i_imm : i_mem_rdata)) == 8'h00))
    else $error("zero flag not from xor result");

  a_flags_kept: assert property (
    @(posedge i_mclk) disable iff (!i_rst_b || !i_ce)
    accept && i_op < mtis_pkg::OP_XOR_MEM |=> $stable(o_zero_flag))
    else $error("non-xor op changed zero flag");
endmodule

/* File: logic/mtis_pkg.sv */
// constants and opcode codes for the tail instruction execution unit
package mtis_pkg;
  localparam logic [3:0] OP_SWAP = 4'h0;
  localparam logic [3:0] OP_SWAP_W = 4'h1;
  localparam logic [3:0] OP_SKIP_NIL = 4'h2;
  localparam logic [3:0] OP_LOAD_SKIP = 4'h3;
  localparam logic [3:0] OP_SKIP_BIT = 4'h4;
  localparam logic [3:0] OP_TBL_CUR = 4'h5;
  localparam logic [3:0] OP_TBL_LAST = 4'h6;
  localparam logic [3:0] OP_XOR_MEM = 4'h7;
  localparam logic [3:0] OP_XOR_TO_MEM = 4'h8;
  localparam logic [3:0] OP_XOR_IMM = 4'h9;
  localparam int NIBBLE_W = 4;
  localparam int PC_W_DEF = 13;
  localparam int TP_W_DEF = 8;
  localparam logic [7:0] WREG_RST = 8'h00;
  localparam logic [7:0] TABLE_HIGH_LATCH_RST = 8'h00;
  localparam logic ZERO_RST = 1'b0;
  localparam int SKIP_CYCLES = 2;
  localparam int TABLE_CYCLES = 2;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_DUMMY = 2'b01,
    ST_TABLE = 2'b10
  } mtis_state_e;
endpackage

/* File: tb/mcu_tail_instruction_semantics_tb.sv */
// self-checking bench for the tail instruction execution unit
`timescale 1ns/1ns
module mcu_tail_instruction_semantics_tb;
  logic i_mclk;
  logic i_rst_b;
  logic i_ce;
  logic i_issue;
  logic [3:0] i_op;
  logic [2:0] i_bit_sel;
  logic [7:0] i_imm;
  logic [7:0] i_mem_rdata;
  logic [7:0] i_table_pointer;
  logic [12:0] i_pc;
  logic [15:0] i_rom_data;
  logic o_ready;
  logic o_discard;
  logic [7:0] o_working_register;
  logic [7:0] o_table_high_latch;
  logic o_zero_flag;
  logic o_mem_we;
  logic [7:0] o_mem_wdata;
  logic o_rom_en;
  logic [12:0] o_rom_addr;
  int failures = 0;
  int num_checks = 0;

  mtis_exec #(.PC_W(13), .TP_W(8)) dut (.i_mclk(i_mclk), .i_rst_b(i_rst_b),
    .i_ce(i_ce), .i_issue(i_issue), .i_op(i_op), .i_bit_sel(i_bit_sel),
    .i_imm(i_imm), .i_mem_rdata(i_mem_rdata),
    .i_table_pointer(i_table_pointer), .i_pc(i_pc),
    .i_rom_data(i_rom_data), .o_ready(o_ready), .o_discard(o_discard),
    .o_working_register(o_working_register),
    .o_table_high_latch(o_table_high_latch), .o_zero_flag(o_zero_flag),
    .o_mem_we(o_mem_we), .o_mem_wdata(o_mem_wdata), .o_rom_en(o_rom_en),
    .o_rom_addr(o_rom_addr));
  mtis_rom_model #(.AW(13)) u_rom (.i_en(o_rom_en), .i_addr(o_rom_addr),
    .o_data(i_rom_data));

  initial begin
    i_mclk = 1'b0;
    forever #5 i_mclk = ~i_mclk;
  end

  task automatic give_verdict();
    $display("checks=%0d failures=%0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("unexpected t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // issues one instruction; returns at the falling edge of cycle 1
  task automatic run(input logic [3:0] op, input logic [7:0] mem,
                     input logic [7:0] imm, input logic [2:0] bs);
    int n;
    n = 0;
    @(negedge i_mclk);
    while (o_ready !== 1'b1) begin
      @(negedge i_mclk);
      n++;
      if (n > 4) begin
        failures++;
        give_verdict();
      end
    end
    i_issue = 1'b1;
    i_op = op;
    i_mem_rdata = mem;
    i_imm = imm;
    i_bit_sel = bs;
    @(negedge i_mclk);
    i_issue = 1'b0;
    // the data bus moves on once the issue cycle is over
    i_mem_rdata = ~mem;
  endtask

  task automatic skip(input logic [3:0] op, input logic [7:0] mem,
                      input logic [2:0] bs, input logic met);
    run(op, mem, 8'h00, bs);
    chk(16'({o_discard, o_ready}), met ? 16'h0002 : 16'h0001);
    chk(16'(o_mem_we), 16'h0000);
    if (met) begin
      @(negedge i_mclk);
      chk(16'({o_discard, o_ready}), 16'h0001);
    end
  endtask

  task automatic t_swap();
    run(mtis_pkg::OP_SWAP_W, 8'ha5, 8'h00, 3'h0);
    chk(16'({o_mem_we, o_working_register}), 16'h005a);
    run(mtis_pkg::OP_SWAP, 8'h3c, 8'h00, 3'h0);
    chk(16'({o_mem_we, o_mem_wdata}), 16'h01c3);
    chk(16'({o_zero_flag, o_working_register}), 16'h005a);
    @(negedge i_mclk);
    chk(16'(o_mem_we), 16'h0000);
    $display("swap test done");
  endtask

  task automatic t_skip();
    skip(mtis_pkg::OP_SKIP_NIL, 8'h00, 3'h0, 1'b1);
    skip(mtis_pkg::OP_SKIP_NIL, 8'h01, 3'h0, 1'b0);
    skip(mtis_pkg::OP_SKIP_BIT, 8'hf7, 3'h3, 1'b1);
    skip(mtis_pkg::OP_SKIP_BIT, 8'hf7, 3'h2, 1'b0);
    skip(mtis_pkg::OP_LOAD_SKIP, 8'h00, 3'h0, 1'b1);
    chk(16'(o_working_register), 16'h0000);
    skip(mtis_pkg::OP_LOAD_SKIP, 8'h80, 3'h0, 1'b0);
    chk(16'(o_working_register), 16'h0080);
    $display("skip test done");
  endtask

  task automatic t_xor();
    run(mtis_pkg::OP_XOR_MEM, 8'h80, 8'h00, 3'h0);
    chk(16'({o_zero_flag, o_working_register}), 16'h0100);
    skip(mtis_pkg::OP_SKIP_NIL, 8'h00, 3'h0, 1'b1);
    chk(16'(o_zero_flag), 16'h0001);
    run(mtis_pkg::OP_XOR_TO_MEM, 8'h0f, 8'h00, 3'h0);
    chk(16'({o_mem_we, o_mem_wdata}), 16'h010f);
    chk(16'({o_zero_flag, o_working_register}), 16'h0000);
    run(mtis_pkg::OP_XOR_IMM, 8'h55, 8'h3c, 3'h0);
    chk(16'({o_zero_flag, o_working_register}), 16'h003c);
    run(mtis_pkg::OP_XOR_IMM, 8'h55, 8'h3c, 3'h0);
    chk(16'({o_zero_flag, o_working_register}), 16'h0100);
    $display("xor test done");
  endtask

  // an offer made while the clock enable is low must leave no trace,
  // and an unused opcode must pass as a one-cycle no-op
  task automatic t_freeze();
    @(negedge i_mclk);
    i_ce = 1'b0;
    i_issue = 1'b1;
    i_op = mtis_pkg::OP_XOR_IMM;
    i_imm = 8'hff;
    @(negedge i_mclk);
    chk(16'({o_mem_we, o_zero_flag, o_working_register}), 16'h0100);
    chk(16'({o_ready, o_discard}), 16'h0002);
    i_issue = 1'b0;
    i_ce = 1'b1;
    run(4'hf, 8'h00, 8'hff, 3'h0);
    chk(16'({o_mem_we, o_zero_flag, o_working_register}), 16'h0100);
    chk(16'({o_ready, o_discard}), 16'h0002);
    $display("freeze test done");
  endtask

  task automatic t_table(input logic [3:0] op, input logic [4:0] page);
    logic [15:0] w;
    w = 16'({page, 8'h12}) ^ 16'h5ac3;
    i_pc = 13'h1a34;
    i_table_pointer = 8'h12;
    run(op, 8'h00, 8'h00, 3'h0);
    chk(16'({o_rom_en, o_ready, o_mem_we}), 16'h0004);
    chk(16'(o_rom_addr), 16'({page, 8'h12}));
    @(negedge i_mclk);
    chk(16'({o_rom_en, o_mem_we, o_mem_wdata}),
        16'(w[7:0]) | 16'h0100);
    chk(16'(o_table_high_latch), 16'(w[15:8]));
    chk(16'(o_zero_flag), 16'h0001);
    $display("table test done");
  endtask

  initial begin
    i_rst_b = 1'b0;
    i_ce = 1'b1;
    i_issue = 1'b0;
    i_op = 4'h0;
    i_bit_sel = 3'h0;
    i_imm = 8'h00;
    i_mem_rdata = 8'h00;
    i_table_pointer = 8'h00;
    i_pc = 13'h0000;
    repeat (16) @(negedge i_mclk);
    i_rst_b = 1'b1;
    chk(16'({o_ready, o_discard, o_rom_en, o_mem_we, o_zero_flag}), 16'h0010);
    chk(16'(o_working_register), 16'h0000);
    t_swap();
    t_skip();
    t_xor();
    t_freeze();
    t_table(mtis_pkg::OP_TBL_CUR, 5'h1a);
    t_table(mtis_pkg::OP_TBL_LAST, 5'h1f);
    give_verdict();
  end
endmodule

/* File: tb/mtis_rom_model.sv */
// program memory model that answers the table fetch port
`timescale 1ns/1ns
module mtis_rom_model #(
  parameter int AW = 13
) (
  input wire logic i_en,
  input wire logic [AW-1:0] i_addr,
  output logic [15:0] o_data
);
  logic [15:0] word;
  // content is a simple scramble of the address, easy to predict
  assign word = 16'(i_addr) ^ 16'h5ac3;
  // outside a fetch the bus shows junk, so a late sample is caught
  assign o_data = i_en ? word : ~word;
endmodule
